// ### include/fcs_regs.svh
// fcs_regs.svh: offsets, command codes, status bit positions and timing
// assumes a 50 MHz system clock; included by the flash controller
`ifndef FCS_REGS_SVH
`define FCS_REGS_SVH

// register byte offsets on the avalon slave
`define FCS_REG_CTRL    8'h00
`define FCS_REG_ADDR    8'h04
`define FCS_REG_WDATA   8'h08
`define FCS_REG_COUNT   8'h0C
`define FCS_REG_STATUS  8'h10
`define FCS_REG_RDATA   8'h14
`define FCS_REG_BUF     8'h20
`define FCS_OP_LAST     4'h9

// command codes sent on the flash data lines
`define FCS_CMD_READ_ARRAY   16'h00FF
`define FCS_CMD_READ_STATUS  16'h0070
`define FCS_CMD_CLEAR_STATUS 16'h0050
`define FCS_CMD_BLK_ERASE    16'h0020
`define FCS_CMD_BANK_ERASE   16'h0030
`define FCS_CMD_WORD_WRITE   16'h0040
`define FCS_CMD_BUF_WRITE    16'h00E8
`define FCS_CMD_CONFIRM      16'h00D0
`define FCS_CMD_SUSPEND      16'h00B0
`define FCS_CMD_LOCK_SETUP   16'h0060
`define FCS_CMD_LOCK_CONFIRM 16'h0001

// op_status_reg and buffer_status_reg bit positions
`define FCS_SR_READY     7
`define FCS_SR_ERASE_ERR 5
`define FCS_SR_WRITE_ERR 4
`define FCS_SR_SUSPENDED 2
`define FCS_XSR_AVAIL    7
`define FCS_SR_ERR_MASK  8'h3A
`define FCS_SR_RESET     8'h80

// bus timing, figures in ns, counts rounded up
`define FCS_CLK_NS 20
`define FCS_T_WE_NS 60
`define FCS_T_RD_NS 100
`define FCS_WE_CYC ((`FCS_T_WE_NS + `FCS_CLK_NS - 1) / `FCS_CLK_NS)
`define FCS_RD_CYC ((`FCS_T_RD_NS + `FCS_CLK_NS - 1) / `FCS_CLK_NS)

`endif

// ### include/fcs_pkg.sv
// fcs_pkg: operation codes, sequencer states and the flash pin bundle
// assumes nothing beyond a SystemVerilog compiler
`default_nettype none
package fcs_pkg;
    typedef enum logic [3:0] {
        FCS_OP_READ_ARRAY  = 4'h0, FCS_OP_READ_STATUS = 4'h1,
        FCS_OP_CLEAR       = 4'h2, FCS_OP_BLK_ERASE   = 4'h3,
        FCS_OP_BANK_ERASE  = 4'h4, FCS_OP_WORD_WRITE  = 4'h5,
        FCS_OP_BUF_WRITE   = 4'h6, FCS_OP_LOCK_SET    = 4'h7,
        FCS_OP_SUSPEND     = 4'h8, FCS_OP_RESUME      = 4'h9
    } fcs_op_e;
    typedef enum logic [3:0] {
        FCS_ST_IDLE  = 4'h0, FCS_ST_PRE70  = 4'h1, FCS_ST_PREPOLL = 4'h2,
        FCS_ST_SETUP = 4'h3, FCS_ST_READ   = 4'h4, FCS_ST_XREAD   = 4'h5,
        FCS_ST_COUNT = 4'h6, FCS_ST_BUFDAT = 4'h7, FCS_ST_CONFIRM = 4'h8,
        FCS_ST_POLL  = 4'h9, FCS_ST_CLR    = 4'hA, FCS_ST_FINAL   = 4'hB
    } fcs_state_e;
    typedef struct packed {
        logic [20:0] addr;
        logic [15:0] dq;
        logic        dq_oe;
        logic        ce_b;
        logic        we_b;
        logic        oe_b;
        logic        rp_b;
    } fcs_pins_s;
endpackage
`default_nettype wire

// ### hw/fcs_host.sv
// fcs_host: host controller that sequences commands into a parallel flash
// assumes a flash on the pin bundle and software on avalon-mm
//
// Functional notes
// - poll status ready bit before each new operation and after confirm.
// - block erase is 20H then D0H, both inside the block.
// - bank erase is 30H then D0H anywhere; failure in bit 5.
// - error bits stay set until the clear-status command.
// - word write is 40H or 10H then data, same location.
// - after the last operation write FFH to return to array read; read status, clear and resume end here without FFH.
// - buffered write starts with E8H; proceed when buffer bit 7 set.
// - write count minus one on low eight data lines.
// - then buffer words and D0H; programming starts at start address.
// - aborted buffered write flags sequence error; host clears status.
// - aligning buffered start address to buffer boundary is advised.
// - mask buffer status bits 6 to 0 when polling.
// - B0H suspends a write; status bit 2 shows suspended or done.
// - while suspended read array via FFH; D0H resumes.
// - lock bit set is 60H then 01H at the block address.
`include "fcs_regs.svh"
`timescale 1ns/1ps
`default_nettype none

module fcs_host (
    // clock and reset
    input  wire logic              i_clk,
    input  wire logic              i_rst_b,
    // avalon-mm slave
    input  wire logic [7:0]        i_avs_address,
    input  wire logic              i_avs_read,
    input  wire logic              i_avs_write,
    input  wire logic [31:0]       i_avs_writedata,
    input  wire logic [3:0]        i_avs_byteenable,
    output var  logic [31:0]       o_avs_readdata,
    output var  logic              o_avs_waitrequest,
    // flash pins
    input  wire logic [15:0]       i_fl_dq,
    output var  fcs_pkg::fcs_pins_s o_fl
);
    import fcs_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // declarations
    fcs_state_e  state;
    fcs_state_e  next_state;
    fcs_op_e     op;
    logic [3:0]  tcnt;
    logic [3:0]  step_len;
    logic        step_end;
    logic        is_rd;
    logic [15:0] cur_code;
    logic [20:0] cur_addr;
    logic [15:0] rd_s1;
    logic [15:0] rd_s2;
    logic [20:0] addr_reg;
    logic [15:0] wdata;
    logic [1:0]  cnt;
    logic [1:0]  idx;
    logic [15:0] buf_mem [4];
    logic [7:0]  sr_snap;
    logic [7:0]  sr_err;
    logic        xsr_avail;
    logic [15:0] rdata;
    logic        acc_wr;
    logic        start;
    logic [31:0] view;
    logic [31:0] merged;
    logic        seq_err;

    // per-lane write merge for every writable register except ctrl
    function automatic logic [31:0] be_merge(input logic [31:0] old,
                                             input logic [31:0] nw,
                                             input logic [3:0]  be);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++)
        begin
            if (be[i])
                r[8*i +: 8] = nw[8*i +: 8];
        end
        return r;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // avalon slave: fixed one-cycle wait, then answer
    assign acc_wr = i_avs_write && !o_avs_waitrequest;
    assign start  = acc_wr && i_avs_address == `FCS_REG_CTRL
                    && state == FCS_ST_IDLE && i_avs_byteenable[0]
                    && i_avs_writedata[3:0] <= `FCS_OP_LAST;
    assign seq_err = sr_snap[`FCS_SR_ERASE_ERR] & sr_snap[`FCS_SR_WRITE_ERR];

    // register view for reads and merges
    always_comb
    begin
        view = 32'h0;
        case (i_avs_address)
            `FCS_REG_CTRL:   view = {28'h0, op};
            `FCS_REG_ADDR:   view = {11'h0, addr_reg};
            `FCS_REG_WDATA:  view = {16'h0, wdata};
            `FCS_REG_COUNT:  view = {30'h0, cnt};
            `FCS_REG_STATUS: view = {20'h0, xsr_avail, seq_err,
                                     state != FCS_ST_IDLE,
                                     sr_snap[`FCS_SR_SUSPENDED], sr_err | {
                                     sr_snap[7:6], 1'b0, 1'b0, 1'b0,
                                     sr_snap[2], 2'b00}};
            `FCS_REG_RDATA:  view = {16'h0, rdata};
            default:
            begin
                // every aligned word of the buffer window
                if ({i_avs_address[7:4], 4'h0} == `FCS_REG_BUF
                    && i_avs_address[1:0] == 2'b00)
                    view = {16'h0, buf_mem[i_avs_address[3:2]]};
            end
        endcase
    end
    assign merged = be_merge(view, i_avs_writedata, i_avs_byteenable);

    // waitrequest and read data
    always_ff @(posedge i_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            o_avs_waitrequest <= 1'b1;
            o_avs_readdata    <= 32'h0;
        end
        else
        begin
            o_avs_waitrequest <= !((i_avs_read || i_avs_write)
                                   && o_avs_waitrequest);
            if (i_avs_read && o_avs_waitrequest)
                o_avs_readdata <= view;
        end
    end

    // software-written registers
    always_ff @(posedge i_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            op       <= FCS_OP_READ_ARRAY;
            addr_reg <= 21'h0;
            wdata    <= 16'h0;
            cnt      <= 2'h0;
            for (int i = 0; i < 4; i++)
                buf_mem[i] <= 16'h0;
        end
        else if (acc_wr)
        begin
            if (start)
                op <= fcs_op_e'(i_avs_writedata[3:0]);
            if (i_avs_address == `FCS_REG_ADDR)
                addr_reg <= merged[20:0];
            if (i_avs_address == `FCS_REG_WDATA)
                wdata <= merged[15:0];
            if (i_avs_address == `FCS_REG_COUNT)
                cnt <= merged[1:0];
            if ({i_avs_address[7:4], 4'h0} == `FCS_REG_BUF
                && i_avs_address[1:0] == 2'b00)
                buf_mem[i_avs_address[3:2]] <= merged[15:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // step decode: what the current state puts on the flash bus
    always_comb
    begin
        is_rd    = 1'b0;
        cur_code = `FCS_CMD_READ_ARRAY;
        cur_addr = addr_reg;
        case (state)
            FCS_ST_PRE70:   cur_code = `FCS_CMD_READ_STATUS;
            FCS_ST_PREPOLL, FCS_ST_READ, FCS_ST_XREAD, FCS_ST_POLL:
                is_rd = 1'b1;
            FCS_ST_SETUP:
            begin
                case (op)
                    FCS_OP_READ_STATUS: cur_code = `FCS_CMD_READ_STATUS;
                    FCS_OP_CLEAR:       cur_code = `FCS_CMD_CLEAR_STATUS;
                    FCS_OP_BLK_ERASE:   cur_code = `FCS_CMD_BLK_ERASE;
                    FCS_OP_BANK_ERASE:  cur_code = `FCS_CMD_BANK_ERASE;
                    FCS_OP_WORD_WRITE:  cur_code = `FCS_CMD_WORD_WRITE;
                    FCS_OP_BUF_WRITE:   cur_code = `FCS_CMD_BUF_WRITE;
                    FCS_OP_LOCK_SET:    cur_code = `FCS_CMD_LOCK_SETUP;
                    FCS_OP_SUSPEND:     cur_code = `FCS_CMD_SUSPEND;
                    FCS_OP_RESUME:      cur_code = `FCS_CMD_CONFIRM;
                    default:            cur_code = `FCS_CMD_READ_ARRAY;
                endcase
            end
            FCS_ST_COUNT:   cur_code = {14'h0, cnt};
            FCS_ST_BUFDAT:
            begin
                cur_code = buf_mem[idx];
                cur_addr = addr_reg + {19'h0, idx};
            end
            FCS_ST_CONFIRM:
            begin
                case (op)
                    FCS_OP_WORD_WRITE: cur_code = wdata;
                    FCS_OP_LOCK_SET:   cur_code = `FCS_CMD_LOCK_CONFIRM;
                    default:           cur_code = `FCS_CMD_CONFIRM;
                endcase
            end
            FCS_ST_CLR:     cur_code = `FCS_CMD_CLEAR_STATUS;
            default:        cur_code = `FCS_CMD_READ_ARRAY;
        endcase
        step_len = is_rd ? 4'(`FCS_RD_CYC + 2) : 4'(`FCS_WE_CYC + 2);
    end
    assign step_end = state != FCS_ST_IDLE && tcnt == step_len;

    ////////////////////////////////////////////////////////////////////////
    // sequencer next state
    always_comb
    begin
        next_state = state;
        case (state)
            FCS_ST_IDLE:
                if (start)
                    next_state = FCS_ST_PRE70;
            FCS_ST_PRE70:
                if (step_end)
                    next_state = FCS_ST_PREPOLL;
            FCS_ST_PREPOLL:
                if (step_end && rd_s2[`FCS_SR_READY])
                    next_state = FCS_ST_SETUP;
            FCS_ST_SETUP:
            begin
                if (step_end)
                begin
                    case (op)
                        FCS_OP_READ_ARRAY, FCS_OP_READ_STATUS:
                            next_state = FCS_ST_READ;
                        FCS_OP_CLEAR, FCS_OP_RESUME:
                            next_state = FCS_ST_IDLE;
                        FCS_OP_BUF_WRITE: next_state = FCS_ST_XREAD;
                        FCS_OP_SUSPEND:   next_state = FCS_ST_POLL;
                        default:          next_state = FCS_ST_CONFIRM;
                    endcase
                end
            end
            FCS_ST_READ:
                if (step_end)
                    next_state = FCS_ST_IDLE;
            FCS_ST_XREAD:
                if (step_end)
                    next_state = rd_s2[`FCS_XSR_AVAIL] ? FCS_ST_COUNT
                                                       : FCS_ST_SETUP;
            FCS_ST_COUNT:
                if (step_end)
                    next_state = FCS_ST_BUFDAT;
            FCS_ST_BUFDAT:
                if (step_end && idx == cnt)
                    next_state = FCS_ST_CONFIRM;
            FCS_ST_CONFIRM:
                if (step_end)
                    next_state = FCS_ST_POLL;
            FCS_ST_POLL:
            begin
                if (step_end && rd_s2[`FCS_SR_READY])
                    next_state = (op == FCS_OP_BUF_WRITE
                                  && rd_s2[5] && rd_s2[4])
                                 ? FCS_ST_CLR : FCS_ST_FINAL;
            end
            FCS_ST_CLR:
                if (step_end)
                    next_state = FCS_ST_FINAL;
            FCS_ST_FINAL:
                if (step_end)
                    next_state = FCS_ST_IDLE;
            default:
                next_state = FCS_ST_IDLE;
        endcase
    end

    // state, step timer and buffer index
    always_ff @(posedge i_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            state <= FCS_ST_IDLE;
            tcnt  <= 4'h0;
            idx   <= 2'h0;
        end
        else
        begin
            state <= next_state;
            tcnt  <= (state == FCS_ST_IDLE || step_end) ? 4'h0
                                                        : tcnt + 4'h1;
            if (state == FCS_ST_COUNT)
                idx <= 2'h0;
            else if (state == FCS_ST_BUFDAT && step_end)
                idx <= idx + 2'h1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // read data synchroniser, two stages
    always_ff @(posedge i_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            rd_s1 <= 16'h0;
            rd_s2 <= 16'h0;
        end
        else
        begin
            rd_s1 <= i_fl_dq;
            rd_s2 <= rd_s1;
        end
    end

    // status capture; error bits sticky until a clear
    always_ff @(posedge i_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            sr_snap   <= `FCS_SR_RESET;
            sr_err    <= 8'h0;
            xsr_avail <= 1'b0;
            rdata     <= 16'h0;
        end
        else if (step_end)
        begin
            if (state == FCS_ST_POLL && rd_s2[`FCS_SR_READY])
            begin
                sr_snap <= rd_s2[7:0];
                sr_err  <= sr_err | (rd_s2[7:0] & `FCS_SR_ERR_MASK);
            end
            if (state == FCS_ST_SETUP && op == FCS_OP_CLEAR)
            begin
                sr_err  <= 8'h0;
                sr_snap <= `FCS_SR_RESET;
            end
            if (state == FCS_ST_XREAD)
                xsr_avail <= rd_s2[`FCS_XSR_AVAIL];
            if (state == FCS_ST_READ)
                rdata <= rd_s2;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // flash pin drive; reset pin held low during our reset
    always_ff @(posedge i_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
            o_fl <= '{addr: 21'h0, dq: 16'h0, dq_oe: 1'b0, ce_b: 1'b1,
                      we_b: 1'b1, oe_b: 1'b1, rp_b: 1'b0};
        else
        begin
            o_fl.rp_b <= 1'b1;
            if (state != FCS_ST_IDLE && tcnt == 4'h0)
            begin
                o_fl.ce_b  <= 1'b0;
                o_fl.addr  <= cur_addr;
                o_fl.dq    <= cur_code;
                o_fl.dq_oe <= !is_rd;
                o_fl.oe_b  <= !is_rd;
            end
            if (!is_rd && tcnt == 4'h1)
                o_fl.we_b <= 1'b0;
            if (!is_rd && tcnt == 4'(`FCS_WE_CYC + 1))
                o_fl.we_b <= 1'b1;
            if (step_end)
            begin
                o_fl.ce_b  <= 1'b1;
                o_fl.oe_b  <= 1'b1;
                o_fl.dq_oe <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // assertions
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_rst_b);

    a_ready_before_setup: assert property (
        $changed(state) && state == FCS_ST_SETUP
        && $past(state) == FCS_ST_PREPOLL |-> $past(rd_s2[7]))
        else $error("setup issued while device busy");
    a_erase_confirm: assert property (
        state == FCS_ST_CONFIRM && op == FCS_OP_BLK_ERASE && !o_fl.we_b
        |-> o_fl.dq == `FCS_CMD_CONFIRM && o_fl.addr == addr_reg)
        else $error("block erase confirm wrong");
    a_bank_setup: assert property (
        state == FCS_ST_SETUP && op == FCS_OP_BANK_ERASE && !o_fl.we_b
        |-> o_fl.dq == `FCS_CMD_BANK_ERASE)
        else $error("bank erase setup code wrong");
    a_flags_sticky: assert property (
        $fell(sr_err[5]) || $fell(sr_err[4]) |-> $past(op) == FCS_OP_CLEAR)
        else $error("error flag dropped without clear");
    a_word_data: assert property (
        state == FCS_ST_CONFIRM && op == FCS_OP_WORD_WRITE && !o_fl.we_b
        |-> o_fl.dq == wdata && o_fl.addr == addr_reg)
        else $error("word write data phase wrong");
    a_final_ff: assert property (
        state == FCS_ST_FINAL && !o_fl.we_b
        |-> o_fl.dq == `FCS_CMD_READ_ARRAY ##[1:8] state == FCS_ST_IDLE)
        else $error("array read not restored");
    a_xsr_gate: assert property (
        state == FCS_ST_COUNT && $past(state) == FCS_ST_XREAD
        |-> $past(rd_s2[7]))
        else $error("count written without buffer ready");
    a_count_lines: assert property (
        state == FCS_ST_COUNT && !o_fl.we_b
        |-> o_fl.dq[15:8] == 8'h00 && o_fl.dq[7:0] == {6'h0, cnt})
        else $error("count value wrong");
    a_abort_clear: assert property (
        state == FCS_ST_POLL && step_end && rd_s2[7] && rd_s2[5]
        && rd_s2[4] && op == FCS_OP_BUF_WRITE |=> state == FCS_ST_CLR)
        else $error("no clear after aborted buffer write");
    a_lock_confirm: assert property (
        state == FCS_ST_CONFIRM && op == FCS_OP_LOCK_SET && !o_fl.we_b
        |-> o_fl.dq == `FCS_CMD_LOCK_CONFIRM)
        else $error("lock confirm code wrong");

    c_blk_erase: cover property (
        state == FCS_ST_FINAL && op == FCS_OP_BLK_ERASE
        ##1 state == FCS_ST_IDLE);
    c_buf_write: cover property (
        state == FCS_ST_BUFDAT ##1 state == FCS_ST_CONFIRM);
    c_suspend: cover property (
        op == FCS_OP_SUSPEND && sr_snap[2] && state == FCS_ST_IDLE);
endmodule // fcs_host

`default_nettype wire

// ### tb/fcs_flash_model.sv
// fcs_flash_model: behavioural flash on the host pin bundle
// assumes the bench resolves the data wire and picks the fault kind
`timescale 1ns/1ps
`default_nettype none
module fcs_flash_model (
    // clock, pins and fault kind
    input  wire logic              i_clk,
    input  wire fcs_pkg::fcs_pins_s i_pins,
    input  wire logic [1:0]        i_fault,
    // data lines and protocol watch
    output var  logic [15:0]       o_dq,
    output var  logic              o_misuse
);
    import fcs_pkg::*;
    localparam int BLK = 15;
    logic [15:0] mem [int];
    logic [6:0]  opst = 7'h00;
    logic [7:0]  pend = 8'h00;
    logic [1:0]  mode = 2'h0;
    logic        avail = 1'b0;
    logic [20:0] start = 21'h0;
    logic [7:0]  left = 8'h00;
    logic [15:0] last = 16'h0000;
    logic        ok;
    int          busy = 0;
    initial o_misuse = 1'b0;
    initial o_dq = 16'h0000;
    // start the engine; the fault kind decides the error flags
    task automatic launch(input logic [6:0] eb);
        busy = 20;
        if (i_fault == 2'h1) opst = opst | eb;
        if (i_fault == 2'h2) opst = opst | eb | 7'h02;
        if (i_fault == 2'h3) opst = opst | eb | 7'h08;
    endtask
    // command decode
    task automatic cmd(input logic [15:0] d, input logic [20:0] a);
        if (busy != 0 && d[7:0] != 8'h70 && d[7:0] != 8'hB0)
            o_misuse = 1'b1;
        mode = 2'h1;
        if (d[7:0] == 8'hE8 && pend inside {8'h00, 8'hE8})
        begin
            avail = (pend == 8'hE8);
            pend = 8'hE8;
            start = a;
            mode = 2'h2;
        end
        else if (pend == 8'h00)
            case (d[7:0])
                8'hFF: mode = 2'h0;
                8'h70: mode = 2'h1;
                8'h50: opst = 7'h00;
                8'hB0: opst[2] = (busy != 0);
                8'hD0: opst[2] = 1'b0;
                8'h20, 8'h30, 8'h40, 8'h10, 8'h60: pend = d[7:0];
                default: opst = opst | 7'h30;
            endcase
        else if (pend == 8'hE8)
        begin
            left = d[7:0];
            pend = avail ? 8'hE9 : 8'h00;
            if (!avail) opst = opst | 7'h30;
        end
        else if (pend == 8'hE9)
        begin
            mem[int'(a)] = d;
            pend = (a[20:BLK] != start[20:BLK]) ? 8'h00
                 : ((left == 8'h00) ? 8'hEA : 8'hE9);
            left = left - 8'h01;
            if (pend == 8'h00) opst = opst | 7'h30;
        end
        else
        begin
            ok = pend inside {8'h40, 8'h10}
                 || d[7:0] == ((pend == 8'h60) ? 8'h01 : 8'hD0);
            if (pend inside {8'h40, 8'h10} && i_fault == 2'h0)
                mem[int'(a)] = d;
            if (ok)
                launch(pend inside {8'h20, 8'h30} ? 7'h20 : 7'h10);
            else
                opst = opst | 7'h30;
            pend = 8'h00;
        end
    endtask
    // commands taken on the rising write strobe
    always @(posedge i_pins.we_b)
    begin
        if (!i_pins.ce_b) cmd(i_pins.dq, i_pins.addr);
    end
    // engine time and read data; deselected lines show the inverse
    always @(posedge i_clk)
    begin
        if (busy > 0) busy = busy - 1;
        if (!i_pins.ce_b && !i_pins.oe_b)
        begin
            last = {8'h00, busy == 0, opst};
            if (mode == 2'h2) last = {8'h00, avail, 7'h00};
            if (mode == 2'h0) last = mem.exists(int'(i_pins.addr))
                ? mem[int'(i_pins.addr)] : 16'hFFFF;
            o_dq <= last;
        end
        else
            o_dq <= ~last;
    end
    // power-down pin: status cleared, array read mode
    always @(negedge i_pins.rp_b)
    begin
        opst = 7'h00;
        mode = 2'h0;
        pend = 8'h00;
        busy = 0;
    end
endmodule // fcs_flash_model
`default_nettype wire

// ### tb/testbench.sv
// testbench: drives fcs_host over avalon against the flash model
// assumes fcs_host, fcs_flash_model and the offsets header
`include "fcs_regs.svh"
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import fcs_pkg::*;
    logic        i_clk = 1'b0;
    logic        i_rst_b = 1'b0;
    logic [7:0]  i_avs_address = 8'h00;
    logic        i_avs_read = 1'b0;
    logic        i_avs_write = 1'b0;
    logic [31:0] i_avs_writedata = 32'h0;
    logic [3:0]  i_avs_byteenable = 4'hF;
    logic [31:0] o_avs_readdata;
    logic        o_avs_waitrequest;
    fcs_pins_s   o_fl;
    logic [15:0] i_fl_dq;
    logic [15:0] m_dq;
    logic [1:0]  fault = 2'h0;
    logic        misuse;
    logic [31:0] rv;
    int          miscompares = 0;
    int          n_compared = 0;
    localparam logic [3:0] OPS [5] = '{FCS_OP_BLK_ERASE, FCS_OP_BANK_ERASE,
        FCS_OP_WORD_WRITE, FCS_OP_LOCK_SET, FCS_OP_BLK_ERASE};
    localparam logic [1:0] FLT [5] = '{2'h1, 2'h1, 2'h1, 2'h2, 2'h3};
    localparam logic [7:0] ERR [5] = '{8'h20, 8'h20, 8'h10, 8'h12, 8'h28};
    // clock and wire resolution
    always #10 i_clk = ~i_clk;
    assign i_fl_dq = o_fl.dq_oe ? o_fl.dq : m_dq;
    fcs_host i_fcs_host (.i_clk(i_clk), .i_rst_b(i_rst_b),
        .i_avs_address(i_avs_address), .i_avs_read(i_avs_read),
        .i_avs_write(i_avs_write), .i_avs_writedata(i_avs_writedata),
        .i_avs_byteenable(i_avs_byteenable),
        .o_avs_readdata(o_avs_readdata),
        .o_avs_waitrequest(o_avs_waitrequest), .i_fl_dq(i_fl_dq),
        .o_fl(o_fl));
    fcs_flash_model i_fcs_flash_model (.i_clk(i_clk), .i_pins(o_fl),
        .i_fault(fault), .o_dq(m_dq), .o_misuse(misuse));
    // verdict and end of run
    task automatic close_out();
        $display("compared %0d mismatched %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            miscompares++;
            $display("CHECK FAILED at %0t got %h exp %h", $time, got, exp);
        end
    endtask
    // one avalon access, held until waitrequest is sampled low
    task automatic bus(input logic [7:0] ad, input logic w,
                       input logic [31:0] wd);
        int n;
        n = 0;
        @(posedge i_clk);
        i_avs_address <= ad;
        i_avs_read <= !w;
        i_avs_write <= w;
        i_avs_writedata <= wd;
        do
        begin
            @(posedge i_clk);
            n++;
        end
        while (o_avs_waitrequest !== 1'b0 && n < 50);
        rv = o_avs_readdata;
        i_avs_read <= 1'b0;
        i_avs_write <= 1'b0;
        if (n >= 50)
        begin
            miscompares++;
            close_out();
        end
    endtask
    // start an operation and poll busy until it drops
    task automatic run(input logic [3:0] op);
        int n;
        bus(`FCS_REG_CTRL, 1'b1, {28'h0, op});
        n = 0;
        do
        begin
            bus(`FCS_REG_STATUS, 1'b0, 32'h0);
            n++;
        end
        while (rv[9] !== 1'b0 && n < 3000);
        if (n >= 3000)
        begin
            miscompares++;
            close_out();
        end
    endtask
    initial
    begin
        repeat (2) @(posedge i_clk);
        i_rst_b <= 1'b1;
        // word write, then read back in array mode
        bus(`FCS_REG_ADDR, 1'b1, 32'h10);
        bus(`FCS_REG_WDATA, 1'b1, 32'hA5C3);
        run(FCS_OP_WORD_WRITE);
        run(FCS_OP_READ_ARRAY);
        bus(`FCS_REG_RDATA, 1'b0, 32'h0);
        chk(rv, 32'h0000A5C3);
        $display("test word write done");
        // each fault stays over a clean op and goes on clear
        for (int i = 0; i < 5; i++)
        begin
            fault <= FLT[i];
            run(OPS[i]);
            fault <= 2'h0;
            run(FCS_OP_WORD_WRITE);
            bus(`FCS_REG_STATUS, 1'b0, 32'h0);
            chk(rv & 32'h3A, {24'h0, ERR[i]});
            run(FCS_OP_CLEAR);
            bus(`FCS_REG_STATUS, 1'b0, 32'h0);
            chk(rv & 32'h3A, 32'h0);
        end
        $display("test fault flags done");
        // buffered write of four words, each read back
        bus(`FCS_REG_COUNT, 1'b1, 32'h3);
        for (int i = 0; i < 4; i++)
            bus(`FCS_REG_BUF + 8'(4 * i), 1'b1, 32'h1111 * (i + 1));
        bus(`FCS_REG_ADDR, 1'b1, 32'h100);
        run(FCS_OP_BUF_WRITE);
        for (int i = 0; i < 4; i++)
        begin
            bus(`FCS_REG_ADDR, 1'b1, 32'h100 + i);
            run(FCS_OP_READ_ARRAY);
            bus(`FCS_REG_RDATA, 1'b0, 32'h0);
            chk(rv, 32'h1111 * (i + 1));
        end
        // buffered write crossing a block edge is aborted
        bus(`FCS_REG_ADDR, 1'b1, 32'h7FFE);
        run(FCS_OP_BUF_WRITE);
        bus(`FCS_REG_STATUS, 1'b0, 32'h0);
        chk(rv & 32'hC00, 32'hC00);
        run(FCS_OP_CLEAR);
        $display("test buffered write done");
        // suspend with nothing running reports completed
        run(FCS_OP_SUSPEND);
        bus(`FCS_REG_STATUS, 1'b0, 32'h0);
        chk(rv & 32'h300, 32'h0);
        run(FCS_OP_RESUME);
        // bad op code ignored, unmapped offset reads zero
        bus(`FCS_REG_CTRL, 1'b1, 32'hA);
        bus(`FCS_REG_STATUS, 1'b0, 32'h0);
        chk(rv & 32'h200, 32'h0);
        bus(8'h40, 1'b0, 32'h0);
        chk(rv, 32'h0);
        // byte lanes: partial merge, ctrl refused without lane 0
        bus(`FCS_REG_ADDR, 1'b1, 32'h12345);
        i_avs_byteenable <= 4'h1;
        bus(`FCS_REG_ADDR, 1'b1, 32'hFFFFFFAA);
        i_avs_byteenable <= 4'hE;
        bus(`FCS_REG_CTRL, 1'b1, 32'h5);
        i_avs_byteenable <= 4'hF;
        bus(`FCS_REG_ADDR, 1'b0, 32'h0);
        chk(rv, 32'h000123AA);
        bus(`FCS_REG_STATUS, 1'b0, 32'h0);
        chk(rv & 32'h200, 32'h0);
        chk({31'h0, misuse}, 32'h0);
        $display("test suspend and refusal done");
        close_out();
    end
endmodule // testbench
`default_nettype wire
